// ===== src/abt_pkg.sv
// Package of constants for the block transport message framer
package abt_pkg;
    // Status words
    localparam logic [15:0] SW_SUCCESS      = 16'h9000;
    localparam logic [15:0] SW_TOOLKIT_BUSY = 16'h9300;
    localparam logic [7:0]  SW1_PENDING     = 8'h91;
    localparam logic [7:0]  SW1_NORMAL      = 8'h61;
    localparam logic [7:0]  SW1_WARN_A      = 8'h62;
    localparam logic [7:0]  SW1_WARN_B      = 8'h63;
    localparam logic [3:0]  SW1_APP_NIB     = 4'h9;
    // Reserved identifier of the optional telecom directory
    localparam logic [15:0] TELECOM_DIR_FID = 16'h7F10;
    // Command header length and field positions
    localparam int          HDR_LEN         = 4;
    localparam int          IDX_CLA         = 0;
    localparam int          IDX_INS         = 1;
    localparam int          IDX_P1          = 2;
    localparam int          IDX_P2          = 3;
    localparam int          IDX_P3          = 4;
    // Command cases
    localparam logic [1:0]  CASE_1          = 2'h0;
    localparam logic [1:0]  CASE_2          = 2'h1;
    localparam logic [1:0]  CASE_3          = 2'h2;
    localparam logic [1:0]  CASE_4          = 2'h3;
    // Default per-block information field size and message size limit
    localparam int          INF_MAX_DEF     = 32;
    localparam int          MSG_MAX_DEF     = 261;
endpackage : abt_pkg

// ===== src/abt_sw_filter.sv
// Status word classifier: decides whether response data may accompany a status
`timescale 1ns/1ps
module abt_sw_filter (
    input  wire logic [15:0] status_word,
    input  wire logic        pending_cmd,
    output logic      [15:0] status_out,
    output logic             data_allowed
);
    logic [7:0] sw1;

    always_comb
    begin
        // Pending proactive command replaces plain success only
        if (pending_cmd && status_word == abt_pkg::SW_SUCCESS)
            status_out = {abt_pkg::SW1_PENDING, 8'h00};   // [R12]
        else
            status_out = status_word;
        sw1 = status_out[15:8];
        data_allowed = (sw1 == abt_pkg::SW1_NORMAL) || (sw1 == abt_pkg::SW1_WARN_A)
                    || (sw1 == abt_pkg::SW1_WARN_B)
                    || (sw1[7:4] == abt_pkg::SW1_APP_NIB);   // [R3] [R4]
    end
endmodule : abt_sw_filter

// ===== src/abt_framer.sv
// Card-side command/response message framer over chained information blocks
// What the document requires
// [R1] Terminal puts command unchanged into information field
// [R2] Card returns data and status in field
// [R3] Data allowed with 61XX, 62XX, 63XX, 9XXX
// [R4] Other status words return only two bytes
// [R5] Case 1: four header bytes, status reply
// [R6] Case 2 response may chain over blocks
// [R7] Terminal sends case 3/4 commands, maybe chained
// [R8] Case 3 reply is status bytes only
// [R9] Case 4 response may chain over blocks
// [R10] Cases classified by command/response data presence
// [R11] Exactly one response per command message
// [R12] May replace 9000 by 91XX when pending
// [R13] Terminal fetches pending command, then reports
// [R14] Answer 9300 when toolkit cannot take envelope
// [R15] Envelope handled as case 4 with data
// [R16] Terminal: 9000 envelope data is positive acknowledgement
// [R17] Terminal: 62XX/63XX envelope data is negative
// [R18] Telecom directory identifier is 7F 10
// [R19] All blocks but last are chained, in order
`timescale 1ns/1ps
module abt_framer #(
    parameter int INF_MAX = abt_pkg::INF_MAX_DEF,
    parameter int MSG_MAX = abt_pkg::MSG_MAX_DEF
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Incoming information field bytes from the block layer
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_last,
    input  wire logic        rx_chained,
    // Command processing side
    output logic             cmd_valid,
    output logic [1:0]       cmd_case,
    output logic [7:0]       cmd_ins,
    output logic [8:0]       cmd_lc,
    output logic [8:0]       cmd_le,
    input  wire logic        resp_valid,
    input  wire logic [15:0] resp_sw,
    input  wire logic [8:0]  resp_len,
    input  wire logic        pending_cmd,
    input  wire logic        toolkit_busy,
    input  wire logic        envelope_cmd,
    // Response data read port into the processing side's buffer
    output logic [8:0]       resp_rd_idx,
    input  wire logic [7:0]  resp_rd_data,
    // Outgoing information field bytes to the block layer
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_byte,
    output logic             tx_last,
    output logic             tx_chained,
    output logic [15:0]      telecom_fid
);
    if (INF_MAX < 3 || INF_MAX > 254 || MSG_MAX < 5 || MSG_MAX > 511)
    begin : g_bad_param
        $error("abt_framer: unsupported INF_MAX or MSG_MAX");
    end

    typedef enum logic [3:0] {
        ST_RX   = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_DATA = 4'b0100,
        ST_SW   = 4'b1000
    } abt_state_e;

    typedef struct packed {
        abt_state_e  state;
        logic [8:0]  rx_cnt;
        logic        cmd_valid;
        logic [1:0]  cmd_case;
        logic [7:0]  cmd_ins;
        logic [8:0]  cmd_lc;
        logic [8:0]  cmd_le;
        logic [15:0] sw;
        logic [8:0]  data_len;
        logic [8:0]  tx_cnt;
        logic [7:0]  blk_cnt;
        logic        sw_half;
        logic        tx_valid;
        logic [7:0]  tx_byte;
        logic        tx_last;
        logic        tx_chained;
    } abt_regs_s;

    abt_regs_s   st_reg;
    abt_regs_s   st_next;
    logic [7:0]  hdr [0:abt_pkg::IDX_P3];
    logic [15:0] sw_eff;
    logic        data_ok;
    logic [15:0] sw_raw;
    logic [8:0]  rx_total;
    logic        tx_take;
    logic [7:0]  inf_max8;

    assign inf_max8 = 8'(INF_MAX);

    // Header bytes kept; command data body bytes are counted but not stored or passed on
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            for (int i = 0; i <= abt_pkg::IDX_P3; i++)
                hdr[i] <= 8'h00;
        else if (st_reg.state == ST_RX && rx_valid && st_reg.rx_cnt <= 9'(abt_pkg::IDX_P3))
            hdr[st_reg.rx_cnt[2:0]] <= rx_byte;   // [R19]
    end

    assign sw_raw = toolkit_busy && envelope_cmd ? abt_pkg::SW_TOOLKIT_BUSY : resp_sw; // [R14]

    abt_sw_filter u_filter (
        .status_word  (sw_raw),
        .pending_cmd  (pending_cmd),
        .status_out   (sw_eff),
        .data_allowed (data_ok)
    );

    assign rx_total = st_reg.rx_cnt + 9'h001;
    assign tx_take  = st_reg.tx_valid && tx_ready;

    always_comb
    begin
        st_next = st_reg;
        st_next.cmd_valid = 1'b0;
        if (tx_take)
            st_next.tx_valid = 1'b0;
        case (st_reg.state)
            ST_RX:
            begin
                if (rx_valid)
                begin
                    st_next.rx_cnt = rx_total;   // [R1]
                    if (rx_last && !rx_chained)
                    begin
                        // Length and the P3 byte tell the case apart
                        st_next.cmd_ins = (st_reg.rx_cnt > 9'(abt_pkg::IDX_INS))
                                        ? hdr[abt_pkg::IDX_INS] : rx_byte;
                        if (rx_total <= 9'(abt_pkg::HDR_LEN))
                        begin
                            st_next.cmd_case = abt_pkg::CASE_1;   // [R5] [R10]
                            st_next.cmd_lc   = 9'h000;
                            st_next.cmd_le   = 9'h000;
                        end
                        else if (rx_total == 9'(abt_pkg::HDR_LEN + 1))
                        begin
                            st_next.cmd_case = abt_pkg::CASE_2;   // [R10]
                            st_next.cmd_lc   = 9'h000;
                            st_next.cmd_le   = (rx_byte == 8'h00) ? 9'h100 : {1'b0, rx_byte};
                        end
                        else if (rx_total == 9'(abt_pkg::HDR_LEN + 1) + {1'b0, hdr[abt_pkg::IDX_P3]})
                        begin
                            st_next.cmd_case = abt_pkg::CASE_3;   // [R10] [R7]
                            st_next.cmd_lc   = {1'b0, hdr[abt_pkg::IDX_P3]};
                            st_next.cmd_le   = 9'h000;
                        end
                        else
                        begin
                            st_next.cmd_case = abt_pkg::CASE_4;   // [R10] [R15]
                            st_next.cmd_lc   = {1'b0, hdr[abt_pkg::IDX_P3]};
                            st_next.cmd_le   = (rx_byte == 8'h00) ? 9'h100 : {1'b0, rx_byte};
                        end
                        st_next.cmd_valid = 1'b1;   // [R11]
                        st_next.state     = ST_EXEC;
                    end
                end
            end
            ST_EXEC:
            begin
                if (resp_valid)
                begin
                    st_next.sw       = sw_eff;   // [R12]
                    st_next.tx_cnt   = 9'h000;
                    st_next.blk_cnt  = 8'h00;
                    st_next.sw_half  = 1'b0;
                    // Data only for data-carrying cases and permitted status
                    if (data_ok && (st_reg.cmd_case == abt_pkg::CASE_2
                                    || st_reg.cmd_case == abt_pkg::CASE_4)
                        && resp_len != 9'h000)   // [R3] [R4] [R8]
                    begin
                        st_next.data_len = resp_len;
                        st_next.state    = ST_DATA;
                    end
                    else
                    begin
                        st_next.data_len = 9'h000;
                        st_next.state    = ST_SW;
                    end
                end
            end
            ST_DATA:
            begin
                if (!st_reg.tx_valid || tx_take)
                begin
                    st_next.tx_valid = 1'b1;
                    st_next.tx_byte  = resp_rd_data;   // [R2] [R6] [R9]
                    // Block boundary: chain unless this block ends the message
                    st_next.tx_last  = (st_reg.blk_cnt == inf_max8 - 8'h01);   // [R19]
                    st_next.tx_chained = (st_reg.blk_cnt == inf_max8 - 8'h01);  // [R19]
                    st_next.blk_cnt  = (st_reg.blk_cnt == inf_max8 - 8'h01)
                                     ? 8'h00 : st_reg.blk_cnt + 8'h01;
                    st_next.tx_cnt   = st_reg.tx_cnt + 9'h001;
                    if (st_reg.tx_cnt + 9'h001 == st_reg.data_len)
                        st_next.state = ST_SW;
                end
            end
            ST_SW:
            begin
                if (!st_reg.tx_valid || tx_take)
                begin
                    st_next.tx_valid = 1'b1;
                    st_next.tx_byte  = st_reg.sw_half ? st_reg.sw[7:0] : st_reg.sw[15:8]; // [R2]
                    st_next.tx_chained = st_reg.sw_half ? 1'b0
                                       : (st_reg.blk_cnt == inf_max8 - 8'h01);
                    st_next.tx_last  = st_reg.sw_half
                                     || (st_reg.blk_cnt == inf_max8 - 8'h01);
                    st_next.blk_cnt  = (st_reg.blk_cnt == inf_max8 - 8'h01)
                                     ? 8'h00 : st_reg.blk_cnt + 8'h01;
                    st_next.sw_half  = 1'b1;
                    if (st_reg.sw_half)
                    begin
                        st_next.rx_cnt = 9'h000;
                        st_next.state  = ST_RX;   // [R11]
                    end
                end
            end
            default:
            begin
                st_next.state = ST_RX;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg       <= '0;
            st_reg.state <= ST_RX;
        end
        else
            st_reg <= st_next;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            telecom_fid <= 16'h0000;
        else
            telecom_fid <= abt_pkg::TELECOM_DIR_FID;   // [R18]
    end

    assign resp_rd_idx = st_reg.tx_cnt;
    assign cmd_valid   = st_reg.cmd_valid;
    assign cmd_case    = st_reg.cmd_case;
    assign cmd_ins     = st_reg.cmd_ins;
    assign cmd_lc      = st_reg.cmd_lc;
    assign cmd_le      = st_reg.cmd_le;
    assign tx_valid    = st_reg.tx_valid;
    assign tx_byte     = st_reg.tx_byte;
    assign tx_last     = st_reg.tx_last;
    assign tx_chained  = st_reg.tx_chained;

    sequence resp_taken_s;
        st_reg.state == ST_EXEC && resp_valid;
    endsequence

    sequence first_byte_s;
        !tx_valid ##1 tx_valid;
    endsequence

    first_reply_a: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
        resp_taken_s |=> first_byte_s)
        else $error("first reply byte not offered in time");
    one_response_a: assert property (@(posedge mclk) disable iff (!resetn) // [R11]
        cmd_valid |=> !cmd_valid [*2])
        else $error("second command strobe without a response");
    case1_sw_only_a: assert property (@(posedge mclk) disable iff (!resetn) // [R5]
        (st_reg.state == ST_EXEC && resp_valid && cmd_case == abt_pkg::CASE_1)
        |=> st_reg.state == ST_SW)
        else $error("case 1 reply carried data");
    case3_sw_only_a: assert property (@(posedge mclk) disable iff (!resetn) // [R8]
        (st_reg.state == ST_EXEC && resp_valid && cmd_case == abt_pkg::CASE_3)
        |=> st_reg.state == ST_SW)
        else $error("case 3 reply carried data");
    no_data_bad_sw_a: assert property (@(posedge mclk) disable iff (!resetn) // [R4]
        (st_reg.state == ST_EXEC && resp_valid && !data_ok) |=> st_reg.state != ST_DATA)
        else $error("data sent with a non data status");
    pending_sub_a: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
        (st_reg.state == ST_EXEC && resp_valid && pending_cmd && !toolkit_busy
         && resp_sw == abt_pkg::SW_SUCCESS) |=> st_reg.sw[15:8] == abt_pkg::SW1_PENDING)
        else $error("pending command not signalled");
    toolkit_busy_a: assert property (@(posedge mclk) disable iff (!resetn) // [R14]
        (st_reg.state == ST_EXEC && resp_valid && toolkit_busy && envelope_cmd)
        |=> st_reg.sw == abt_pkg::SW_TOOLKIT_BUSY)
        else $error("busy toolkit not answered with its status");
    chain_last_a: assert property (@(posedge mclk) disable iff (!resetn) // [R19]
        (tx_valid && tx_chained) |-> tx_last)
        else $error("chained mark off a block boundary");
    data_allowed_a: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
        (st_reg.state == ST_DATA) |-> st_reg.sw[15:12] == abt_pkg::SW1_APP_NIB
         || st_reg.sw[15:8] == abt_pkg::SW1_NORMAL || st_reg.sw[15:8] == abt_pkg::SW1_WARN_A
         || st_reg.sw[15:8] == abt_pkg::SW1_WARN_B)
        else $error("data phase with a forbidden status");
    sw_tail_a: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
        (st_reg.state == ST_SW && !st_reg.sw_half && !tx_valid) |=> tx_valid)
        else $error("status bytes not sent");
    fid_a: assert property (@(posedge mclk) disable iff (!resetn) // [R18]
        $past(resetn) |-> telecom_fid == abt_pkg::TELECOM_DIR_FID)
        else $error("telecom directory identifier wrong");
endmodule : abt_framer

// ===== tb/abt_term_model.sv
// Terminal transport model: sends commands as chained blocks, gathers response bytes
`timescale 1ns/1ps
module abt_term_model #(
    parameter int BLK = 3
) (
    input  wire logic       mclk,
    output logic            rx_valid   = 1'b0,
    output logic [7:0]      rx_byte    = 8'h00,
    output logic            rx_last    = 1'b0,
    output logic            rx_chained = 1'b0,
    input  wire logic       tx_valid,
    output logic            tx_ready   = 1'b0,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    input  wire logic       tx_chained,
    input  wire logic       stall
);
    logic [7:0] got[$];
    logic [1:0] flag[$];
    int         cyc = 0;

    // Bytes go out unchanged, one per cycle, every block but the last chained
    task automatic send_cmd(input logic [7:0] cmd[$]);
        for (int i = 0; i < cmd.size(); i++)
        begin
            @(negedge mclk);
            rx_valid   = 1'b1;
            rx_byte    = cmd[i];
            rx_last    = (i % BLK == BLK - 1) || (i == cmd.size() - 1);
            rx_chained = rx_last && (i != cmd.size() - 1);
        end
        @(negedge mclk);
        rx_valid   = 1'b0;
        rx_byte    = ~rx_byte;
        rx_last    = 1'b0;
        rx_chained = 1'b0;
    endtask : send_cmd

    // A slow terminal takes one byte in three
    always @(negedge mclk)
    begin
        cyc      <= cyc + 1;
        tx_ready <= !stall || (cyc % 3 == 0);
    end

    always @(posedge mclk)
    begin
        if (tx_valid && tx_ready)
        begin
            got.push_back(tx_byte);
            flag.push_back({tx_last, tx_chained});
        end
    end
endmodule : abt_term_model

// ===== tb/apdu_block_transport_tb.sv
// Self-checking bench for the block transport message framer
`timescale 1ns/1ps
module apdu_block_transport_tb;
    typedef struct packed {
        logic [1:0]  cs;
        logic [7:0]  lc;
        logic [7:0]  le;
        logic [15:0] sw;
        logic [8:0]  len;
        logic        pend;
        logic        busy;
        logic        env;
        logic [15:0] xsw;
        logic        xdat;
    } abt_row_s;
    localparam int INF = 4;
    logic        mclk         = 1'b0;
    logic        resetn       = 1'b0;
    logic        resp_valid   = 1'b0;
    logic [15:0] resp_sw      = 16'h0000;
    logic [8:0]  resp_len     = 9'h000;
    logic        pending_cmd  = 1'b0;
    logic        toolkit_busy = 1'b0;
    logic        envelope_cmd = 1'b0;
    logic        stall        = 1'b0;
    logic        rx_valid, rx_last, rx_chained, cmd_valid, tx_valid, tx_ready, tx_last;
    logic        tx_chained;
    logic [7:0]  rx_byte, cmd_ins, tx_byte, resp_rd_data;
    logic [1:0]  cmd_case;
    logic [8:0]  cmd_lc, cmd_le, resp_rd_idx;
    logic [15:0] telecom_fid;
    int          miscompares = 0;
    int          check_count = 0;
    int          seen        = 0;
    abt_row_s    rows[15]    = '{
        '{2'h0, 8'h00, 8'h00, 16'h9000, 9'h000, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b0},
        '{2'h1, 8'h00, 8'h08, 16'h9000, 9'h008, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b1},
        '{2'h1, 8'h00, 8'h00, 16'h6A82, 9'h005, 1'b0, 1'b0, 1'b0, 16'h6A82, 1'b0},
        '{2'h2, 8'h06, 8'h00, 16'h9000, 9'h003, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b0},
        '{2'h3, 8'h02, 8'h04, 16'h6310, 9'h004, 1'b0, 1'b0, 1'b0, 16'h6310, 1'b1},
        '{2'h3, 8'h01, 8'h02, 16'h9000, 9'h002, 1'b1, 1'b0, 1'b0, 16'h9100, 1'b1},
        '{2'h1, 8'h00, 8'h02, 16'h9000, 9'h002, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b1},
        '{2'h2, 8'h02, 8'h00, 16'h9000, 9'h000, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b0},
        '{2'h3, 8'h01, 8'h00, 16'h9000, 9'h000, 1'b0, 1'b1, 1'b1, 16'h9300, 1'b0},
        '{2'h1, 8'h00, 8'h05, 16'h6105, 9'h005, 1'b0, 1'b0, 1'b0, 16'h6105, 1'b1},
        '{2'h1, 8'h00, 8'h01, 16'h9F10, 9'h001, 1'b0, 1'b0, 1'b0, 16'h9F10, 1'b1},
        '{2'h3, 8'h02, 8'h03, 16'h6200, 9'h003, 1'b0, 1'b0, 1'b1, 16'h6200, 1'b1},
        '{2'h3, 8'h02, 8'h03, 16'h9000, 9'h003, 1'b0, 1'b0, 1'b1, 16'h9000, 1'b1},
        '{2'h3, 8'h01, 8'h04, 16'h6A80, 9'h004, 1'b0, 1'b0, 1'b0, 16'h6A80, 1'b0},
        '{2'h3, 8'h01, 8'h02, 16'h6310, 9'h002, 1'b1, 1'b0, 1'b0, 16'h6310, 1'b1}
    };

    always #50 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (cmd_valid === 1'b1)
            seen <= seen + 1;
    end

    // Processing side buffer: byte k holds k xor 5A
    assign resp_rd_data = resp_rd_idx[7:0] ^ 8'h5A;

    abt_framer #(.INF_MAX(INF)) i_dut (
        .mclk(mclk), .resetn(resetn), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last), .rx_chained(rx_chained), .cmd_valid(cmd_valid),
        .cmd_case(cmd_case), .cmd_ins(cmd_ins), .cmd_lc(cmd_lc), .cmd_le(cmd_le),
        .resp_valid(resp_valid), .resp_sw(resp_sw), .resp_len(resp_len),
        .pending_cmd(pending_cmd), .toolkit_busy(toolkit_busy),
        .envelope_cmd(envelope_cmd), .resp_rd_idx(resp_rd_idx), .resp_rd_data(resp_rd_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
        .tx_chained(tx_chained), .telecom_fid(telecom_fid)
    );

    abt_term_model i_term (
        .mclk(mclk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
        .rx_chained(rx_chained), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_byte(tx_byte), .tx_last(tx_last), .tx_chained(tx_chained), .stall(stall)
    );

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_val

    task automatic respond(input abt_row_s r);
        @(negedge mclk);
        resp_valid   = 1'b1;
        resp_sw      = r.sw;
        resp_len     = r.len;
        pending_cmd  = r.pend;
        toolkit_busy = r.busy;
        envelope_cmd = r.env;
        @(negedge mclk);
        resp_valid   = 1'b0;
    endtask : respond

    task automatic run_row(input abt_row_s r);
        logic [7:0] cmd[$];
        logic [7:0] exp[$];
        int         n;
        int         k;
        int         b;
        cmd = '{8'h80, {6'h30, r.cs}, 8'h01, 8'h02};
        if (r.cs[1])
            cmd.push_back(r.lc);
        for (int i = 0; i < int'(r.lc) && r.cs[1]; i++)
            cmd.push_back(8'h40 + 8'(i));
        if (r.cs[0])
            cmd.push_back(r.le);
        n = seen;
        i_term.got.delete();
        i_term.flag.delete();
        i_term.send_cmd(cmd);
        for (k = 0; seen == n && k < 50; k++)
            @(negedge mclk);
        check_val(16'(seen - n), 16'h0001);
        check_val(16'(cmd_case), 16'(r.cs));
        check_val(16'(cmd_ins), 16'(cmd[1]));
        if (r.cs[1])
            check_val(16'(cmd_lc), 16'(r.lc));
        if (r.cs[0])
            check_val(16'(cmd_le), (r.le == 8'h00) ? 16'h0100 : 16'(r.le));
        respond(r);
        for (int i = 0; r.xdat && i < int'(r.len); i++)
            exp.push_back(8'(i) ^ 8'h5A);
        exp.push_back(r.xsw[15:8]);
        exp.push_back(r.xsw[7:0]);
        for (k = 0; i_term.got.size() < exp.size() && k < 600; k++)
            @(negedge mclk);
        repeat (6) @(negedge mclk);
        check_val(16'(i_term.got.size()), 16'(exp.size()));
        foreach (exp[i])
        begin
            check_val(16'(i_term.got[i]), 16'(exp[i]));
            b = ((i % INF == INF - 1) || (i == exp.size() - 1)) ? 1 : 0;
            check_val(16'(i_term.flag[i]), {14'h0000, b[0], b[0] && i != exp.size() - 1});
        end
        check_val(16'(seen - n), 16'h0001);
        if (k >= 600 || seen == n)
        begin
            miscompares++;
            close_out();
        end
    endtask : run_row

    initial
    begin
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        check_val(telecom_fid, 16'h7F10);
        foreach (rows[i])
            run_row(rows[i]);
        // A response offered while idle must not start a transfer
        i_term.got.delete();
        respond(rows[1]);
        repeat (8) @(negedge mclk);
        check_val(16'(i_term.got.size()), 16'h0000);
        stall = 1'b1;
        run_row('{2'h1, 8'h00, 8'h0C, 16'h9000, 9'h00C, 1'b0, 1'b0, 1'b0, 16'h9000, 1'b1});
        stall = 1'b0;
        // Reset in mid-response clears the outgoing stream
        i_term.send_cmd('{8'h80, 8'h31, 8'h01, 8'h02, 8'h06});
        respond(rows[1]);
        repeat (3) @(negedge mclk);
        resetn = 1'b0;
        #10;
        check_val(16'({tx_valid, cmd_valid}), 16'h0000);
        @(negedge mclk);
        resetn = 1'b1;
        run_row(rows[1]);
        close_out();
    end
endmodule : apdu_block_transport_tb
